// *** cwd_config_word_decode.sv ***
// configuration word store, decode and reset-hold sequencing
`timescale 1ns/1ps
`default_nettype none
`include "cwd_defines.svh"
module cwd_config_word_decode #(
  parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = `CWD_POWERUP_DELAY_TIMER_CYCLES
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // programming port
  input  wire logic              prog_mode,
  input  wire logic [13:0]       prog_addr,
  input  wire logic              prog_wr,
  input  wire logic              prog_rd,
  input  wire logic [13:0]       prog_wdata,
  output logic      [13:0]       prog_rdata,
  output logic                   prog_rvalid,
  // reset and wake sources
  input  wire logic              por_event,
  input  wire logic              brownout_low,
  input  wire logic              ext_reset_n,
  input  wire logic              watchdog_wake,
  input  wire logic              irq_wake,
  input  wire logic              sleep_req,
  input  wire logic              osc_input_pin,
  input  wire logic              wdt_rc_tick,
  // device size strap
  input  wire cwd_pkg::cwd_mem_t mem_size,
  // decoded outputs
  output logic                   brownout_detect_enable,
  output logic                   powerup_delay_enable,
  output logic                   watchdog_enable_bit,
  output cwd_pkg::cwd_osc_t      osc_mode,
  output logic                   protect_valid,
  output logic      [10:0]       protect_lo,
  output logic                   protect_on,
  output logic                   ext_clock_allowed,
  output logic                   watchdog_tick,
  output logic                   device_reset,
  output logic                   sleeping
);
  // ==========================================================
  // synchronisers for pins
  logic [1:0] bo_s, ext_s, osc_s, rc_s;
  logic       osc_d, rc_d;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bo_s  <= 2'h0;
      ext_s <= 2'h3;
      osc_s <= 2'h0;
      rc_s  <= 2'h0;
      osc_d <= 1'b0;
      rc_d  <= 1'b0;
    end else begin
      bo_s  <= {bo_s[0], brownout_low};
      ext_s <= {ext_s[0], ext_reset_n};
      osc_s <= {osc_s[0], osc_input_pin};
      rc_s  <= {rc_s[0], wdt_rc_tick};
      osc_d <= osc_s[1];
      rc_d  <= rc_s[1];
    end
  end
  wire logic osc_rise = osc_s[1] & ~osc_d;
  // watchdog paced only by its own rc source, not the main oscillator
  assign watchdog_tick = rc_s[1] & ~rc_d & watchdog_enable_bit;

  // ==========================================================
  // non-volatile word
  logic [13:0] word_q;
  wire logic in_cfg = prog_mode && (prog_addr == `CWD_CFG_ADDR);
  // erased cells hold ones; bit 7 has no cell
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      word_q <= `CWD_WORD_ERASED;
    end else if (prog_wr && in_cfg) begin
      word_q <= prog_wdata;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prog_rvalid <= 1'b0;
    end else begin
      prog_rvalid <= prog_rd && prog_mode && (prog_addr >= `CWD_TEST_BASE);
    end
  end
  // any other address reads as zero rather than stale data
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prog_rdata <= 14'h0000;
    end else if (prog_rd && in_cfg) begin
      prog_rdata <= word_q & `CWD_WORD_MASK;
    end else begin
      prog_rdata <= 14'h0000;
    end
  end

  // ==========================================================
  // decode, latched while device held in reset
  logic [1:0] pair;
  logic [2:0] copy_same;
  logic       pairs_same;
  assign pair = word_q[5:4];
  // one compare per upper copy of the protection pair
  for (genvar g = 0; g < 3; g++) begin : g_copy
    assign copy_same[g] = (word_q[8 + 2 * g +: 2] == pair);
  end
  assign pairs_same = &copy_same;

  // ==========================================================
  // protection range
  logic        prot_d;
  logic [10:0] lo_d;
  // lower bound only; the top is always the end of memory
  always_comb begin
    prot_d = 1'b0;
    lo_d   = 11'h000;
    unique case (mem_size)
      cwd_pkg::CWD_MEM_2K: begin
        unique case (pair)
          2'h0: prot_d = 1'b1;
          2'h1: begin
            prot_d = 1'b1;
            lo_d   = 11'h200;
          end
          2'h2: begin
            prot_d = 1'b1;
            lo_d   = 11'h400;
          end
          2'h3: prot_d = 1'b0;
        endcase
      end
      cwd_pkg::CWD_MEM_1K: begin
        unique case (pair)
          2'h0: prot_d = 1'b1;
          2'h1: begin
            prot_d = 1'b1;
            lo_d   = 11'h200;
          end
          2'h2: prot_d = 1'b0;
          2'h3: prot_d = 1'b0;
        endcase
      end
      cwd_pkg::CWD_MEM_05K: begin
        prot_d = (pair == 2'h0);
      end
      default: begin
        prot_d = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // decoded fields
  // fields frozen outside reset; the reset-hold sequencer still reads word_q live, so run-time writes reach it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      brownout_detect_enable <= 1'b1;
    end else if (device_reset) begin
      brownout_detect_enable <= word_q[`CWD_BIT_BOD];
    end
  end
  // brown-out detection is worthless without the delay behind it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      powerup_delay_enable <= 1'b1;
    end else if (device_reset) begin
      powerup_delay_enable <= ~word_q[`CWD_BIT_POWERUP_DELAY_TIMER_DIS] | word_q[`CWD_BIT_BOD];
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      watchdog_enable_bit <= 1'b1;
    end else if (device_reset) begin
      watchdog_enable_bit <= word_q[`CWD_BIT_WDT];
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      osc_mode <= cwd_pkg::CWD_OSC_RC;
    end else if (device_reset) begin
      osc_mode <= cwd_pkg::cwd_osc_t'(word_q[1:0]);
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      protect_on    <= 1'b0;
      protect_lo    <= 11'h000;
      protect_valid <= 1'b1;
    end else if (device_reset) begin
      protect_on    <= prot_d & pairs_same;
      protect_lo    <= lo_d;
      protect_valid <= pairs_same;
    end
  end
  assign ext_clock_allowed = (osc_mode != cwd_pkg::CWD_OSC_RC);

  // ==========================================================
  // reset-hold sequencer
  cwd_pkg::cwd_state_t st_q;
  logic [31:0]         cnt_q;
  logic                por_pend_q;
  logic                sleeping_q;
  wire logic crystal   = (word_q[1:0] != 2'h3);
  wire logic bo_hit    = word_q[`CWD_BIT_BOD] & bo_s[1];
  wire logic powerup_delay_timer_on   = ~word_q[`CWD_BIT_POWERUP_DELAY_TIMER_DIS] | word_q[`CWD_BIT_BOD];
  wire logic restart   = por_event | bo_hit;
  wire logic powerup_delay_timer_done = (cnt_q >= POWERUP_DELAY_TIMER_CYCLES - 1);
  wire logic ost_done  = (cnt_q >= `CWD_OST_CYCLES);
  // power-on or brown-out restarts the whole hold from the beginning
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q <= cwd_pkg::CWD_ST_HOLD;
    end else if (restart) begin
      st_q <= cwd_pkg::CWD_ST_HOLD;
    end else begin
      unique case (st_q)
        cwd_pkg::CWD_ST_HOLD: begin
          if (ext_s[1]) begin
            if (por_pend_q && powerup_delay_timer_on) begin
              st_q <= cwd_pkg::CWD_ST_POWERUP_DELAY_TIMER;
            end else if (por_pend_q && crystal) begin
              st_q <= cwd_pkg::CWD_ST_OST;
            end else begin
              st_q <= cwd_pkg::CWD_ST_RUN;
            end
          end
        end
        cwd_pkg::CWD_ST_POWERUP_DELAY_TIMER: begin
          if (!ext_s[1]) begin
            st_q <= cwd_pkg::CWD_ST_HOLD;
          end else if (powerup_delay_timer_done) begin
            st_q <= crystal ? cwd_pkg::CWD_ST_OST : cwd_pkg::CWD_ST_RUN;
          end
        end
        cwd_pkg::CWD_ST_OST: begin
          if (!ext_s[1]) begin
            st_q <= cwd_pkg::CWD_ST_HOLD;
          end else if (ost_done) begin
            st_q <= cwd_pkg::CWD_ST_RUN;
          end
        end
        cwd_pkg::CWD_ST_RUN: begin
          if (!ext_s[1]) begin
            st_q <= cwd_pkg::CWD_ST_HOLD;
          end else if (sleep_req) begin
            st_q <= cwd_pkg::CWD_ST_SLEEP;
          end
        end
        cwd_pkg::CWD_ST_SLEEP: begin
          if (!ext_s[1]) begin
            st_q <= cwd_pkg::CWD_ST_HOLD;
          end else if (watchdog_wake || irq_wake) begin
            st_q <= crystal ? cwd_pkg::CWD_ST_OST : cwd_pkg::CWD_ST_RUN;
          end
        end
        default: begin
          st_q <= cwd_pkg::CWD_ST_HOLD;
        end
      endcase
    end
  end
  // counter only advances in the two timed hold states
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 32'h0;
    end else if (restart || !ext_s[1]) begin
      cnt_q <= 32'h0;
    end else if (st_q == cwd_pkg::CWD_ST_POWERUP_DELAY_TIMER && !powerup_delay_timer_done) begin
      cnt_q <= cnt_q + 32'h1;
    end else if (st_q == cwd_pkg::CWD_ST_OST && !ost_done) begin
      if (osc_rise) begin
        cnt_q <= cnt_q + 32'h1;
      end
    end else begin
      cnt_q <= 32'h0;
    end
  end
  // delay is owed only after power-on or brown-out; start-up wait also follows a wake from sleep
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      por_pend_q <= 1'b1;
    end else if (restart) begin
      por_pend_q <= 1'b1;
    end else if (st_q == cwd_pkg::CWD_ST_RUN) begin
      por_pend_q <= 1'b0;
    end
  end

  // ==========================================================
  // run flags
  // after a wake the start-up wait does not reset the core
  assign device_reset = (st_q == cwd_pkg::CWD_ST_HOLD) || (st_q == cwd_pkg::CWD_ST_POWERUP_DELAY_TIMER)
                        || (st_q == cwd_pkg::CWD_ST_OST && !sleeping_q);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sleeping_q <= 1'b0;
    end else if (st_q == cwd_pkg::CWD_ST_SLEEP) begin
      sleeping_q <= 1'b1;
    end else if (st_q != cwd_pkg::CWD_ST_OST) begin
      sleeping_q <= 1'b0;
    end
  end
  assign sleeping = sleeping_q | (st_q == cwd_pkg::CWD_ST_SLEEP);
endmodule
`default_nettype wire

// *** cwd_defines.svh ***
// constants for the configuration word decoder
// ==========================================================
// How it works
// - programmed bit reads 0, unprogrammed reads 1; erased word is all ones.
// - word sits at 2007h in 2000h-3FFFh space, reachable only in programming mode.
// - protection pair repeats at word bits 13-8 and 5-4.
// - 2K memory: 11 none, 10 0400h-07FFh, 01 0200h-07FFh, 00 all.
// - 1K memory: 11,10 none, 01 0200h-03FFh, 00 0000h-03FFh.
// - 0.5K memory: only 00 protects 0000h-01FFh.
// - bit 7 is unimplemented and reads 0.
// - bit 6 high enables brown-out reset.
// - bit 3 high disables power-up delay; erased part still has it on, as bit 6 is high.
// - brown-out enable forces the power-up delay on.
// - bit 2 high enables the watchdog.
// - bits 1-0 pick oscillator: 11 RC, 10 HS, 01 XT, 00 LP.
// - enabled power-up delay holds reset 72 ms, after power-on or brown-out only.
// - brown-out reset lasts at least 72 ms.
// - start-up timer holds reset until crystal oscillator is stable.
// - sleep ends on external reset, watchdog wake-up or interrupt.
// - watchdog runs from its own RC oscillator.
// - crystal modes also accept an external clock on the oscillator pin.
// - start-up wait counts 1024 oscillator cycles after delay, crystal modes, POR/brown-out/wake only.
// - brown-out during power-up delay returns to brown-out and restarts delay.
`ifndef CWD_DEFINES_SVH
`define CWD_DEFINES_SVH
`define CWD_CFG_ADDR        14'h2007
`define CWD_TEST_BASE       14'h2000
`define CWD_WORD_ERASED     14'h3fff
`define CWD_WORD_MASK       14'h3f7f
`define CWD_BIT_UNIMPL      7
`define CWD_BIT_BOD         6
`define CWD_BIT_POWERUP_DELAY_TIMER_DIS    3
`define CWD_BIT_WDT         2
`define CWD_CLK_MHZ         100
`define CWD_POWERUP_DELAY_TIMER_MS         72
`define CWD_POWERUP_DELAY_TIMER_CYCLES     (`CWD_POWERUP_DELAY_TIMER_MS * 1000 * `CWD_CLK_MHZ)
`define CWD_OST_CYCLES      1024
`endif

// *** cwd_pkg.sv ***
// types for the configuration word decoder
package cwd_pkg;
  typedef enum logic [1:0] {
    CWD_OSC_LP = 2'h0,
    CWD_OSC_XT = 2'h1,
    CWD_OSC_HS = 2'h2,
    CWD_OSC_RC = 2'h3
  } cwd_osc_t;
  typedef enum logic [1:0] {
    CWD_MEM_05K = 2'h0,
    CWD_MEM_1K  = 2'h1,
    CWD_MEM_2K  = 2'h2
  } cwd_mem_t;
  typedef enum {
    CWD_ST_HOLD,
    CWD_ST_POWERUP_DELAY_TIMER,
    CWD_ST_OST,
    CWD_ST_RUN,
    CWD_ST_SLEEP
  } cwd_state_t;
endpackage

// *** cwd_prog_model.sv ***
// programmer model for the configuration port
`timescale 1ns/1ps
`default_nettype none
module cwd_prog_model (
  // clock
  input  wire logic        clk_sys,
  // programming port
  output logic             prog_mode,
  output logic             prog_wr,
  output logic             prog_rd,
  output logic [13:0]      prog_addr,
  output logic [13:0]      prog_wdata
);
  initial {prog_mode, prog_wr, prog_rd, prog_addr, prog_wdata} = '0;
  // ====
  // word builder; every protection copy gets the same pair
  function automatic logic [13:0] mk(input logic [1:0] c, input logic b, p, w,
                                     input logic [1:0] o);
    return {c, c, c, 1'h1, b, c, p, w, o};
  endfunction
  // one access; released strobes drop to 0, address and data lines show inverted values
  task automatic acc(input logic md, w, input logic [13:0] a, d);
    @(posedge clk_sys);
    {prog_mode, prog_wr, prog_rd, prog_addr, prog_wdata} <= {md, w, !w, a, d};
    @(posedge clk_sys);
    {prog_mode, prog_wr, prog_rd, prog_addr, prog_wdata} <= {3'h0, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// *** cwd_cfg_monitor.sv ***
// assertion checker for the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
module cwd_cfg_monitor #(parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = 100) (
  // clock, reset and programming port
  input wire logic              clk_sys,
  input wire logic              rstn,
  input wire logic              prog_mode,
  input wire logic              prog_rd,
  input wire logic [13:0]       prog_addr,
  input wire logic [13:0]       prog_rdata,
  input wire logic              prog_rvalid,
  // reset sources and decoded outputs
  input wire logic              por_event,
  input wire logic              brownout_low,
  input wire logic              brownout_detect_enable,
  input wire logic              powerup_delay_enable,
  input wire logic              watchdog_enable_bit,
  input wire cwd_pkg::cwd_osc_t osc_mode,
  input wire logic              protect_valid,
  input wire logic              protect_on,
  input wire logic              watchdog_tick,
  input wire logic              device_reset
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ====
  // hold length; an external reset leaves no delay pending
  int unsigned hold_q;
  logic        pend_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hold_q <= '0;
      pend_q <= 1'h1;
    end else begin
      hold_q <= device_reset ? hold_q + 1 : '0;
      if (por_event || (brownout_low && brownout_detect_enable)) pend_q <= 1'h1;
      else if (hold_q != 0 && !device_reset) pend_q <= 1'h0;
    end
  end
  // ====
  // assertions
  sequence s_cfg_rd; prog_mode && prog_rd && prog_addr == 14'h2007; endsequence
  sequence s_bo_low; (brownout_detect_enable && brownout_low) [*3]; endsequence
  sequence s_run2; !device_reset ##1 !device_reset; endsequence
  property p_rd_bit7; s_cfg_rd |=> prog_rvalid && !prog_rdata[7]; endproperty
  a_rd_bit7: assert property (p_rd_bit7) else $error("bad config read");
  property p_rd_lock; !prog_mode |=> !prog_rvalid; endproperty
  a_rd_lock: assert property (p_rd_lock) else $error("read outside programming");
  property p_bod_powerup_delay_timer; brownout_detect_enable |-> powerup_delay_enable; endproperty
  a_bod_powerup_delay_timer: assert property (p_bod_powerup_delay_timer) else $error("delay not forced");
  property p_wdt_gate; watchdog_tick |-> watchdog_enable_bit; endproperty
  a_wdt_gate: assert property (p_wdt_gate) else $error("tick while disabled");
  property p_static; s_run2 |-> $stable({brownout_detect_enable, powerup_delay_enable,
    watchdog_enable_bit, osc_mode, protect_on}); endproperty
  a_static: assert property (p_static) else $error("decode moved in run");
  property p_prot; protect_on |-> protect_valid; endproperty
  a_prot: assert property (p_prot) else $error("protect with unequal pairs");
  property p_powerup_delay_timer_len; pend_q && powerup_delay_enable && hold_q != 0 && !device_reset
    |-> hold_q >= POWERUP_DELAY_TIMER_CYCLES; endproperty
  a_powerup_delay_timer_len: assert property (p_powerup_delay_timer_len) else $error("reset hold too short");
  property p_bo_rst; s_bo_low |-> ##[1:3] device_reset; endproperty
  a_bo_rst: assert property (p_bo_rst) else $error("brown-out without reset");
endmodule
bind cwd_config_word_decode cwd_cfg_monitor #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_CYCLES)) mon_u (
  .clk_sys(clk_sys), .rstn(rstn), .prog_mode(prog_mode), .prog_rd(prog_rd),
  .prog_addr(prog_addr), .prog_rdata(prog_rdata), .prog_rvalid(prog_rvalid),
  .por_event(por_event), .brownout_low(brownout_low),
  .brownout_detect_enable(brownout_detect_enable), .powerup_delay_enable(powerup_delay_enable),
  .watchdog_enable_bit(watchdog_enable_bit), .osc_mode(osc_mode),
  .protect_valid(protect_valid), .protect_on(protect_on), .watchdog_tick(watchdog_tick),
  .device_reset(device_reset));
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys = 1'h0, rstn = 1'h0, por_event = 1'h0, brownout_low = 1'h0, irq_wake = 1'h0;
  logic ext_reset_n = 1'h1, watchdog_wake = 1'h0, sleep_req = 1'h0, prog_rvalid, sleeping;
  logic prog_mode, prog_wr, prog_rd, brownout_detect_enable, powerup_delay_enable, device_reset;
  logic watchdog_enable_bit, protect_valid, protect_on, ext_clock_allowed, watchdog_tick;
  logic [13:0] prog_addr, prog_wdata, prog_rdata, word = 14'h3fff, exp_q[$];
  logic [10:0] protect_lo;
  logic [3:0] div_q = 4'h0;
  cwd_pkg::cwd_osc_t osc_mode;
  cwd_pkg::cwd_mem_t mem_size = cwd_pkg::CWD_MEM_2K;
  wire osc_input_pin = div_q[1];
  wire wdt_rc_tick = div_q[3];
  int n_fail = 0, total_checks = 0;
  cwd_config_word_decode #(.POWERUP_DELAY_TIMER_CYCLES(100)) dut_u (
    .clk_sys(clk_sys), .rstn(rstn), .prog_mode(prog_mode), .prog_addr(prog_addr),
    .prog_wr(prog_wr), .prog_rd(prog_rd), .prog_wdata(prog_wdata), .prog_rdata(prog_rdata),
    .prog_rvalid(prog_rvalid), .por_event(por_event), .brownout_low(brownout_low),
    .ext_reset_n(ext_reset_n), .watchdog_wake(watchdog_wake), .irq_wake(irq_wake),
    .sleep_req(sleep_req), .osc_input_pin(osc_input_pin), .wdt_rc_tick(wdt_rc_tick),
    .mem_size(mem_size), .brownout_detect_enable(brownout_detect_enable),
    .powerup_delay_enable(powerup_delay_enable), .watchdog_enable_bit(watchdog_enable_bit),
    .osc_mode(osc_mode), .protect_valid(protect_valid), .protect_lo(protect_lo),
    .protect_on(protect_on), .ext_clock_allowed(ext_clock_allowed),
    .watchdog_tick(watchdog_tick), .device_reset(device_reset), .sleeping(sleeping));
  cwd_prog_model pm_u (
    .clk_sys(clk_sys), .prog_mode(prog_mode), .prog_wr(prog_wr), .prog_rd(prog_rd),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata));
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) div_q <= div_q + 4'h1;
  // ====
  // checking
  task automatic chk(input string nm, input logic [13:0] e, g);
    total_checks++;
    if (g !== e) n_fail++;
    if (g !== e) $display("BAD %s exp %h got %h", nm, e, g);
  endtask
  task automatic end_sim();
    if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(negedge clk_sys) if (rstn && prog_rvalid !== 1'h0) begin
    if (exp_q.size() == 0) chk("rvalid", 14'h0, 14'h1);
    else chk("rdata", exp_q.pop_front(), prog_rdata);
  end
  initial begin
    #400us;
    n_fail++;
    end_sim();
  end
  // ====
  // stimulus; a read note is queued before the request goes out
  task automatic io(input logic md, w, input logic [13:0] a, d);
    if (md && w && a == 14'h2007) word = d;
    if (md && !w && a >= 14'h2000) exp_q.push_back(a == 14'h2007 ? word & 14'h3f7f : 14'h0);
    pm_u.acc(md, w, a, d);
  endtask
  task automatic wait_run();
    repeat (3) @(negedge clk_sys);
    for (int n = 0; n < 20000 && device_reset !== 1'h0; n++) @(negedge clk_sys);
    chk("rst", 14'h0, device_reset);
  endtask
  initial begin
    logic [1:0] pr, os;
    logic b, p, w;
    int nt;
    void'($urandom(32'h706c));
    repeat (20) @(posedge clk_sys);
    rstn <= 1'h1;
    wait_run();
    chk("erased", 14'h3b, {brownout_detect_enable, powerup_delay_enable,
        watchdog_enable_bit, protect_on, osc_mode});
    io(1'h1, 1'h0, 14'h2007, 14'h0);
    io(1'h0, 1'h0, 14'h2007, 14'h0);
    io(1'h1, 1'h0, 14'h2005, 14'h0);
    io(1'h1, 1'h0, 14'h0100, 14'h0);
    io(1'h0, 1'h1, 14'h2007, 14'h0);
    io(1'h1, 1'h0, 14'h2007, 14'h0);
    for (int i = 0; i < 9; i++) begin
      {pr, b, p, w} = 5'($urandom);
      os = i[1:0];
      if (i == 8) {b, os} = 3'h7;
      mem_size <= cwd_pkg::cwd_mem_t'(i % 3);
      io(1'h1, 1'h1, 14'h2007, pm_u.mk(pr, b, p, w, os) ^ {i == 7, 13'h0});
      io(1'h1, 1'h0, 14'h2007, 14'h0);
      @(posedge clk_sys) por_event <= 1'h1;
      @(posedge clk_sys) por_event <= 1'h0;
      wait_run();
      chk("dec", {b, !p | b, w, os, os != 2'h3, i != 7, i != 7 && pr <= 2'(i % 3)},
          {brownout_detect_enable, powerup_delay_enable, watchdog_enable_bit, osc_mode,
           ext_clock_allowed, protect_valid, protect_on});
      if (protect_on === 1'h1) chk("plo", {pr, 9'h0}, protect_lo);
      nt = 0;
      repeat (32) @(negedge clk_sys) if (watchdog_tick !== 1'h0) nt++;
      chk("wdt", w ? 14'h2 : 14'h0, 14'(nt));
    end
    repeat (2) begin
      @(posedge clk_sys) brownout_low <= 1'h1;
      repeat (8) @(posedge clk_sys);
      brownout_low <= 1'h0;
      repeat (40) @(posedge clk_sys);
      @(negedge clk_sys) chk("bor", 14'h1, device_reset);
    end
    wait_run();
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys) sleep_req <= 1'h1;
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys) chk("slp", 14'h1, sleeping);
      @(posedge clk_sys) {sleep_req, irq_wake, watchdog_wake, ext_reset_n} <= 4'(3'h4 >> k ^ 3'h1);
      repeat (6) @(posedge clk_sys);
      {irq_wake, watchdog_wake, ext_reset_n} <= 3'h1;
      wait_run();
      chk("wake", 14'h0, sleeping);
    end
    repeat (4) @(posedge clk_sys);
    chk("left", 14'h0, 14'(exp_q.size()));
    end_sim();
  end
endmodule
`default_nettype wire
